// ===== intr_consts.svh
`ifndef INTR_CONSTS_SVH
`define INTR_CONSTS_SVH

// APB byte offsets.
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_EVENT 8'h08
`define REG_MASK 8'h0c
`define REG_SAVED_PC 8'h10

// Control register.
`define CTRL_ALLOW_BIT 0
`define CTRL_RESET 1'b1

// Event and mask register layout.
`define EVT_WIDTH 5
`define EVT_START 0
`define EVT_END 1
`define EVT_ENABLE 2
`define EVT_DISABLE 3
`define EVT_POLL 4
`define EVT_RESET 5'h00
`define MASK_RESET 5'h00

// Status register layout.
`define ST_ACCEPT 0
`define ST_STATUS_BIT 1
`define ST_LATCH_LO 2
`define ST_CYCLE_FLAG 5
`define ST_STATE_FLAG 6
`define ST_REQUEST 7
`define ST_AR_LO 16

// Instruction decode.
`define OP_ENABLE_HI 9'h040
`define OP_DISABLE 12'h203
`define WORD_ZERO 12'h000
`define TRAP_IDLE_N 12'hfff

// Priority latch bit positions.
`define LVL_A 0
`define LVL_B 1
`define LVL_N 2

`endif

// ===== intr_pkg.sv
package intr_pkg;
   typedef logic [11:0] word_t;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_front = 2'b01,
      st_back = 2'b11,
      st_release = 2'b10
   } init_state_e;
   typedef enum logic [2:0] {
      sel_control = 3'h0,
      sel_status = 3'h1,
      sel_event = 3'h2,
      sel_mask = 3'h3,
      sel_saved = 3'h4,
      sel_none = 3'h7
   } reg_sel_e;
endpackage

// ===== enable_ctrl_if.sv
`timescale 1ns/1ps
interface enable_ctrl_if;
   logic [11:0] instr_word;
   logic basic_period_five;
   logic basic_period_seven;
   logic cycle_clear;
   logic accept;
   logic status_bit;
   logic strobe_n;
   logic enable_seen;
   logic disable_seen;
   logic [2:0] latch;
   logic [2:0] level_n;
   modport ctrl(
      output instr_word, basic_period_five, basic_period_seven, cycle_clear,
      input accept, status_bit, strobe_n, enable_seen, disable_seen, latch, level_n
   );
   modport keeper(
      input instr_word, basic_period_five, basic_period_seven, cycle_clear,
      output accept, status_bit, strobe_n, enable_seen, disable_seen, latch, level_n
   );
endinterface

// ===== priority_enable.sv
`timescale 1ns/1ps
`include "intr_consts.svh"
module priority_enable import intr_pkg::*; (
   input wire logic core_clk,
   input wire logic reset,
   enable_ctrl_if.keeper bus
);
   logic bp7_q;
   logic accept;
   logic status_bit;
   logic [2:0] latch;
   logic next_accept;
   logic next_status_bit;
   logic [2:0] next_latch;
   logic enable_instr;
   logic disable_instr;
   logic strobe;
   logic disable_hit;

   assign enable_instr = (bus.instr_word[11:3] == `OP_ENABLE_HI) && bus.instr_word[2];
   assign disable_instr = (bus.instr_word == `OP_DISABLE);
   assign strobe = enable_instr && bus.basic_period_seven && !bp7_q; // R10
   assign disable_hit = disable_instr && bus.basic_period_five;

   always_comb begin
      next_accept = accept;
      next_status_bit = status_bit;
      next_latch = latch;
      if (strobe) begin
         // The strobe wins over a clear in the same cycle.
         next_accept = 1'b1; // R9 R10
         next_status_bit = 1'b1; // R11 R12 R13 R14
         next_latch[`LVL_A] = bus.instr_word[0]; // R12 R14
         next_latch[`LVL_B] = bus.instr_word[1]; // R13 R14
         next_latch[`LVL_N] = bus.instr_word[1] & bus.instr_word[0]; // R11 R14
      end else if (disable_hit || bus.cycle_clear) begin
         next_accept = 1'b0; // R2 R9 R16
         next_status_bit = 1'b0; // R9
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         bp7_q <= 1'b0;
         accept <= 1'b0;
         status_bit <= 1'b0;
         latch <= 3'h0;
      end else begin
         bp7_q <= bus.basic_period_seven;
         accept <= next_accept;
         status_bit <= next_status_bit;
         latch <= next_latch;
      end
   end

   assign bus.accept = accept;
   assign bus.status_bit = status_bit;
   assign bus.latch = latch;
   assign bus.strobe_n = !strobe;
   assign bus.enable_seen = strobe;
   assign bus.disable_seen = disable_hit && !strobe;
   assign bus.level_n = ~(latch & {3{accept}}); // R8 R15

   property p_strobe_loads;
      @(posedge core_clk) disable iff (reset)
      !bus.strobe_n |=> accept && status_bit && latch[`LVL_A] == $past(bus.instr_word[0]);
   endproperty
   a_strobe_loads: assert property (p_strobe_loads) // R10
      else $error("enable strobe did not load accept and latch");

   property p_highest_only;
      @(posedge core_clk) disable iff (reset)
      !bus.strobe_n && bus.instr_word[2:0] == 3'h4 |=> status_bit && bus.level_n == 3'h7;
   endproperty
   a_highest_only: assert property (p_highest_only) // R11
      else $error("highest-only enable drove a level enable");

   property p_all_levels;
      @(posedge core_clk) disable iff (reset)
      !bus.strobe_n && bus.instr_word[2:0] == 3'h7 |=> bus.level_n == 3'h0;
   endproperty
   a_all_levels: assert property (p_all_levels) // R14
      else $error("enable-all did not assert every level");

   property p_disable_keeps_latch;
      @(posedge core_clk) disable iff (reset)
      disable_hit && !strobe |=> !accept && !status_bit && $stable(latch) && bus.level_n == 3'h7;
   endproperty
   a_disable_keeps_latch: assert property (p_disable_keeps_latch) // R16
      else $error("disable did not clear accept or changed latch");
endmodule

// ===== interrupt_initiation.sv
// Behaviour
// R1: At period six, increment address register to trap+2 and load it into the PC.
// R2: At period three of initiation, clear the global accept enable.
// R3: At period three, pass the PC unchanged through the adder into the MDR.
// R4: At the trailing edge of period seven, clear both cycle flags.
// R5: At the following period zero, release execute and basic phase blocks.
// R6: Increments use the adder with zero operand and carry-in set.
// R7: With no trap address, the handler starts at location 0002.
// R8: Drive three active-low level enables; peripherals request only while enabled. bus_peripheral lets a highest-level device request at any time.
// R9: Disable clears accept enable and status bit; enabling instructions set both.
// R10: Enabling instruction strobes low in basic period seven, setting accept and latch.
// R11: Pattern 100 sets status bit, leaves all level enables deasserted.
// R12: Pattern 101 sets status bit and asserts only level A enable.
// R13: Pattern 110 sets status bit and asserts only level B enable.
// R14: Pattern 111 sets status bit and asserts all three level enables.
// R15: A level enable is asserted only with its latch bit and accept set.
// R16: Disable clears accept and status bit in basic period five; latch bits unchanged.
// R17: Assert grant; peripheral drives trap lines; undriven lines give trap zero.
// R18: Accepted pending request starts initiation when current instruction completes.
`timescale 1ns/1ps
`include "intr_consts.svh"
module interrupt_initiation import intr_pkg::*; (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [11:0] instr_word,
   input wire logic instr_done,
   input wire logic basic_period_five,
   input wire logic basic_period_seven,
   input wire logic cycle_period_zero,
   input wire logic cycle_period_one,
   input wire logic cycle_period_three,
   input wire logic cycle_period_six,
   input wire logic cycle_period_seven,
   input wire logic [11:0] program_counter,
   input wire logic intr_request_n,
   input wire logic [11:0] trap_vector_line_n,
   output logic intr_grant_n,
   output logic level_a_enable_n,
   output logic level_b_enable_n,
   output logic lowest_level_enable_n,
   output logic priority_latch_strobe_n,
   output logic execute_phase_block_n,
   output logic basic_phase_block_n,
   output logic intr_cycle_flag,
   output logic intr_cycle_state_flag,
   output logic global_accept_enable,
   output logic interrupt_on_status_bit,
   output logic [11:0] address_reg,
   output logic [11:0] mdr_data,
   output logic mdr_load,
   output logic [11:0] pc_load_value,
   output logic pc_load,
   output logic irq
);
   // Adder with a second operand and carry-in; the carry out is dropped.
   function automatic word_t add12(input word_t a, input word_t b, input logic adder_carry_in);
      return 12'({1'b0, a} + {1'b0, b} + {12'h000, adder_carry_in});
   endfunction

   function automatic reg_sel_e decode(input logic [7:0] addr);
      case (addr)
         `REG_CONTROL: decode = sel_control;
         `REG_STATUS: decode = sel_status;
         `REG_EVENT: decode = sel_event;
         `REG_MASK: decode = sel_mask;
         `REG_SAVED_PC: decode = sel_saved;
         default: decode = sel_none;
      endcase
   endfunction

   enable_ctrl_if en_bus();
   priority_enable u_priority_enable (
      .core_clk(core_clk),
      .reset(reset),
      .bus(en_bus.keeper)
   );

   logic req_meta, req_sync, pu7_q, allow, start, pu7_fall;
   word_t trap_meta, trap_sync, trap_word;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
         trap_meta <= `TRAP_IDLE_N;
         trap_sync <= `TRAP_IDLE_N;
         pu7_q <= 1'b0;
      end else begin
         req_meta <= !intr_request_n;
         req_sync <= req_meta;
         trap_meta <= trap_vector_line_n;
         trap_sync <= trap_meta;
         pu7_q <= cycle_period_seven;
      end
   end

   // Undriven lines idle high, which reads as a zero trap address.
   assign trap_word = ~trap_sync; // R17

   assign start = allow && global_accept_enable && req_sync && instr_done
                  && cycle_period_seven; // R18
   assign pu7_fall = pu7_q && !cycle_period_seven;

   init_state_e state, next_state;
   logic next_cycle_flag, next_state_flag, next_grant_n, next_exec_blk_n, next_basic_blk_n;
   logic next_mdr_load, next_pc_load, evt_end, evt_poll;
   word_t next_ar, next_mdr, next_pc_value;

   always_comb begin
      next_state = state;
      next_cycle_flag = intr_cycle_flag;
      next_state_flag = intr_cycle_state_flag;
      next_grant_n = intr_grant_n;
      next_exec_blk_n = execute_phase_block_n;
      next_basic_blk_n = basic_phase_block_n;
      next_ar = address_reg;
      next_mdr = mdr_data;
      next_mdr_load = 1'b0;
      next_pc_value = pc_load_value;
      next_pc_load = 1'b0;
      evt_end = 1'b0;
      evt_poll = 1'b0;
      case (state)
         st_idle: begin
            if (start) begin
               next_cycle_flag = 1'b1; // R18
               next_state_flag = 1'b1;
               next_grant_n = 1'b0; // R17
               next_exec_blk_n = 1'b0;
               next_basic_blk_n = 1'b0;
               next_state = st_front;
            end
         end
         st_front: begin
            if (cycle_period_zero) begin
               next_ar = add12(trap_word, `WORD_ZERO, 1'b1); // R6 R17
               evt_poll = (trap_word == `WORD_ZERO); // R7
            end
            if (cycle_period_one) next_grant_n = 1'b1;
            if (cycle_period_three) begin
               next_mdr = add12(program_counter, `WORD_ZERO, 1'b0); // R3
               next_mdr_load = 1'b1;
            end
            if (cycle_period_six) begin
               next_ar = add12(address_reg, `WORD_ZERO, 1'b1); // R1 R6
               next_pc_value = add12(address_reg, `WORD_ZERO, 1'b1); // R1 R7
               next_pc_load = 1'b1;
               next_state = st_back;
            end
         end
         st_back: begin
            if (pu7_fall) begin
               next_cycle_flag = 1'b0; // R4
               next_state_flag = 1'b0; // R4
               evt_end = 1'b1;
               next_state = st_release;
            end
         end
         st_release: begin
            if (cycle_period_zero) begin
               next_exec_blk_n = 1'b1; // R5
               next_basic_blk_n = 1'b1; // R5
               next_state = st_idle;
            end
         end
         default: next_state = st_idle;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= st_idle;
         intr_cycle_flag <= 1'b0;
         intr_cycle_state_flag <= 1'b0;
         intr_grant_n <= 1'b1;
         execute_phase_block_n <= 1'b1;
         basic_phase_block_n <= 1'b1;
         address_reg <= `WORD_ZERO;
         mdr_data <= `WORD_ZERO;
         mdr_load <= 1'b0;
         pc_load_value <= `WORD_ZERO;
         pc_load <= 1'b0;
      end else begin
         state <= next_state;
         intr_cycle_flag <= next_cycle_flag;
         intr_cycle_state_flag <= next_state_flag;
         intr_grant_n <= next_grant_n;
         execute_phase_block_n <= next_exec_blk_n;
         basic_phase_block_n <= next_basic_blk_n;
         address_reg <= next_ar;
         mdr_data <= next_mdr;
         mdr_load <= next_mdr_load;
         pc_load_value <= next_pc_value;
         pc_load <= next_pc_load;
      end
   end

   // Link to the enable keeper.
   assign en_bus.instr_word = instr_word;
   assign en_bus.basic_period_five = basic_period_five;
   assign en_bus.basic_period_seven = basic_period_seven;
   assign en_bus.cycle_clear = (state == st_front) && cycle_period_three; // R2
   assign global_accept_enable = en_bus.accept;
   assign interrupt_on_status_bit = en_bus.status_bit;
   assign priority_latch_strobe_n = en_bus.strobe_n; // R10
   assign level_a_enable_n = en_bus.level_n[`LVL_A]; // R8
   assign level_b_enable_n = en_bus.level_n[`LVL_B]; // R8
   assign lowest_level_enable_n = en_bus.level_n[`LVL_N]; // R8

   // APB slave with zero wait states; read data is captured in the setup cycle.
   logic [`EVT_WIDTH-1:0] events, mask, next_events, next_mask, evt_set, evt_clear;
   logic next_allow, next_irq, next_pslverr, setup, access;
   logic [31:0] next_prdata;
   reg_sel_e sel;
   assign sel = decode(paddr);
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign pready = 1'b1;

   always_comb begin
      next_allow = allow;
      next_mask = mask;
      next_prdata = prdata;
      next_pslverr = pslverr;
      evt_set = '0;
      evt_clear = '0;
      evt_set[`EVT_START] = start && (state == st_idle);
      evt_set[`EVT_END] = evt_end;
      evt_set[`EVT_ENABLE] = en_bus.enable_seen;
      evt_set[`EVT_DISABLE] = en_bus.disable_seen;
      evt_set[`EVT_POLL] = evt_poll;
      if (setup) begin
         next_pslverr = (sel == sel_none);
         next_prdata = 32'h0000_0000;
         case (sel)
            sel_control: next_prdata[`CTRL_ALLOW_BIT] = allow;
            sel_status: begin
               next_prdata[`ST_ACCEPT] = global_accept_enable;
               next_prdata[`ST_STATUS_BIT] = interrupt_on_status_bit;
               next_prdata[`ST_LATCH_LO +: 3] = en_bus.latch;
               next_prdata[`ST_CYCLE_FLAG] = intr_cycle_flag;
               next_prdata[`ST_STATE_FLAG] = intr_cycle_state_flag;
               next_prdata[`ST_REQUEST] = req_sync;
               next_prdata[`ST_AR_LO +: 12] = address_reg;
            end
            sel_event: next_prdata[`EVT_WIDTH-1:0] = events;
            sel_mask: next_prdata[`EVT_WIDTH-1:0] = mask;
            sel_saved: next_prdata[11:0] = mdr_data;
            default: next_prdata = 32'h0000_0000;
         endcase
      end
      if (access && pwrite) begin
         case (sel)
            sel_control: next_allow = pwdata[`CTRL_ALLOW_BIT];
            sel_mask: next_mask = pwdata[`EVT_WIDTH-1:0];
            default: next_allow = allow;
         endcase
      end
      if (access && !pwrite && sel == sel_event) evt_clear = prdata[`EVT_WIDTH-1:0];
      // A new event wins over the read that clears it.
      next_events = (events & ~evt_clear) | evt_set;
      next_irq = |(next_events & next_mask);
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         allow <= `CTRL_RESET;
         mask <= `MASK_RESET;
         events <= `EVT_RESET;
         irq <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         allow <= next_allow;
         mask <= next_mask;
         events <= next_events;
         irq <= next_irq;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   property p_start;
      @(posedge core_clk) disable iff (reset)
      start && state == st_idle |=> intr_cycle_flag && !intr_grant_n && !basic_phase_block_n;
   endproperty
   a_start: assert property (p_start) // R18
      else $error("initiation did not start on accepted request");

   property p_pu3;
      @(posedge core_clk) disable iff (reset)
      state == st_front && cycle_period_three && priority_latch_strobe_n
      |=> !global_accept_enable && mdr_load && mdr_data == $past(program_counter);
   endproperty
   a_pu3: assert property (p_pu3) // R2 R3
      else $error("period three did not save PC or clear accept");

   property p_pu6;
      @(posedge core_clk) disable iff (reset)
      state == st_front && cycle_period_six
      |=> pc_load && pc_load_value == address_reg && address_reg == $past(address_reg) + 12'h001;
   endproperty
   a_pu6: assert property (p_pu6) // R1 R6
      else $error("period six did not increment AR into PC");

   property p_zero_trap;
      @(posedge core_clk) disable iff (reset)
      state == st_front && cycle_period_zero && trap_sync == `TRAP_IDLE_N
      |=> address_reg == 12'h001;
   endproperty
   a_zero_trap: assert property (p_zero_trap) // R7 R17
      else $error("undriven trap lines did not give address one");

   property p_end;
      @(posedge core_clk) disable iff (reset)
      state == st_back && pu7_fall |=> !intr_cycle_flag && !intr_cycle_state_flag
      && !execute_phase_block_n && !basic_phase_block_n;
   endproperty
   a_end: assert property (p_end) // R4
      else $error("flags not cleared at end of period seven");

   property p_release;
      @(posedge core_clk) disable iff (reset)
      state == st_release && cycle_period_zero |=> execute_phase_block_n && basic_phase_block_n;
   endproperty
   a_release: assert property (p_release) // R5
      else $error("phase blocks not released at period zero");
endmodule

// ===== bus_peripheral.sv
`timescale 1ns/1ps
module bus_peripheral (
   input wire logic want,
   input wire logic use_level_a,
   input wire logic have_trap,
   input wire logic [11:0] trap,
   input wire logic level_a_enable_n,
   input wire logic intr_grant_n,
   output logic intr_request_n,
   output logic [11:0] trap_vector_line_n
);
   // A level A device asks only while its level is enabled; a highest-level device always may.
   assign intr_request_n = ~(want & (~use_level_a | ~level_a_enable_n));
   // The pulled-up lines read all ones unless granted and a trap address exists.
   assign trap_vector_line_n = (~intr_grant_n & have_trap) ? ~trap : 12'hfff;
endmodule

// ===== interrupt_initiation_and_enable_tb.sv
`timescale 1ns/1ps
`include "intr_consts.svh"
module interrupt_initiation_and_enable_tb import intr_pkg::*;;
   logic core_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rq;
   logic re, instr_done, bp5, bp7, want, use_a, have_trap, req_n, grant_n;
   logic [4:0] pu;
   logic [11:0] instr_word, pc, trap, trap_n, address_reg, mdr_data, pc_load_value;
   logic la_n, lb_n, ll_n, strobe_n, blk_e_n, blk_b_n, cyc_flag, state_flag;
   logic accept, status, mdr_load, pc_load, irq;
   int failures, comparisons;

   interrupt_initiation i_dut (
      .core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .instr_word(instr_word),
      .instr_done(instr_done), .basic_period_five(bp5), .basic_period_seven(bp7),
      .cycle_period_zero(pu[0]), .cycle_period_one(pu[1]), .cycle_period_three(pu[2]),
      .cycle_period_six(pu[3]), .cycle_period_seven(pu[4]), .program_counter(pc),
      .intr_request_n(req_n), .trap_vector_line_n(trap_n), .intr_grant_n(grant_n),
      .level_a_enable_n(la_n), .level_b_enable_n(lb_n), .lowest_level_enable_n(ll_n),
      .priority_latch_strobe_n(strobe_n), .execute_phase_block_n(blk_e_n),
      .basic_phase_block_n(blk_b_n), .intr_cycle_flag(cyc_flag),
      .intr_cycle_state_flag(state_flag), .global_accept_enable(accept),
      .interrupt_on_status_bit(status), .address_reg(address_reg), .mdr_data(mdr_data),
      .mdr_load(mdr_load), .pc_load_value(pc_load_value), .pc_load(pc_load), .irq(irq)
   );

   bus_peripheral i_peer (
      .want(want), .use_level_a(use_a), .have_trap(have_trap), .trap(trap),
      .level_a_enable_n(la_n), .intr_grant_n(grant_n), .intr_request_n(req_n),
      .trap_vector_line_n(trap_n)
   );

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic conclude();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Holds one instruction for a single basic period and looks at the strobe within it.
   task automatic instr(input logic [11:0] w, input logic b7, input logic b5);
      @(posedge core_clk);
      instr_word <= w;
      bp7 <= b7;
      bp5 <= b5;
      @(negedge core_clk);
      if (b7) chk(32'(strobe_n), 32'h0);
      @(posedge core_clk);
      bp7 <= 1'b0;
      bp5 <= 1'b0;
      @(negedge core_clk);
   endtask

   // Raises one initiation period for one cycle, then looks after the edge that took it.
   task automatic step(input logic [4:0] v);
      @(posedge core_clk);
      pu <= v;
      @(posedge core_clk);
      pu <= 5'h00;
      instr_done <= 1'b0;
      @(negedge core_clk);
   endtask

   task automatic t_reset();
      apb(1'b0, `REG_CONTROL, 32'h0);
      chk(rq, 32'h1);
      apb(1'b0, `REG_MASK, 32'h0);
      chk(rq, 32'h0);
      chk(32'({grant_n, la_n, lb_n, ll_n, strobe_n, blk_e_n, blk_b_n}), 32'h7f);
      chk(32'({cyc_flag, state_flag, accept, status, irq}), 32'h0);
      $display("test reset done");
   endtask

   task automatic t_enable();
      logic [2:0] e;
      logic [2:0] x;
      for (int k = 0; k < 4; k++) begin
         e = 3'(k);
         x = ~{e[1] & e[0], e[1], e[0]};
         instr(12'h204 | 12'(k), 1'b1, 1'b0);
         chk(32'(accept), 32'h1);
         chk(32'(status), 32'h1);
         chk(32'({ll_n, lb_n, la_n}), 32'(x));
      end
      $display("test enable done");
   endtask

   task automatic t_disable();
      instr(12'h205, 1'b1, 1'b0);
      instr(12'h203, 1'b0, 1'b1);
      chk(32'(accept), 32'h0);
      chk(32'(status), 32'h0);
      chk(32'({ll_n, lb_n, la_n}), 32'h7);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rq, 32'h0000_0004);
      $display("test disable done");
   endtask

   task automatic t_init(input logic [11:0] tv, input logic have, input logic lvl_a);
      logic [11:0] t;
      t = have ? tv : 12'h000;
      @(posedge core_clk);
      want <= 1'b1;
      use_a <= lvl_a;
      have_trap <= have;
      trap <= tv;
      instr(lvl_a ? 12'h205 : 12'h204, 1'b1, 1'b0);
      repeat (3) @(posedge core_clk);
      instr_done <= 1'b1;
      step(5'b10000);
      chk(32'({cyc_flag, state_flag, grant_n}), 32'h6);
      chk(32'({blk_e_n, blk_b_n}), 32'h0);
      repeat (4) @(posedge core_clk);
      want <= 1'b0;
      step(5'b00001);
      chk(32'(address_reg), 32'(t + 12'h001));
      step(5'b00010);
      chk(32'(grant_n), 32'h1);
      step(5'b00100);
      chk(32'({mdr_load, mdr_data}), 32'({1'b1, pc}));
      chk(32'({accept, status}), 32'h0);
      step(5'b01000);
      chk(32'(address_reg), 32'(t + 12'h002));
      chk(32'({pc_load, pc_load_value}), 32'({1'b1, t + 12'h002}));
      step(5'b10000);
      @(posedge core_clk);
      @(negedge core_clk);
      chk(32'({cyc_flag, state_flag, blk_e_n, blk_b_n}), 32'h0);
      step(5'b00001);
      chk(32'({blk_e_n, blk_b_n}), 32'h3);
      $display("test initiation done");
   endtask

   task automatic t_irq();
      apb(1'b1, `REG_MASK, 32'h11);
      repeat (2) @(posedge core_clk);
      chk(32'(irq), 32'h1);
      apb(1'b0, `REG_EVENT, 32'h0);
      chk(32'({rq[4], rq[0]}), 32'h3);
      repeat (2) @(posedge core_clk);
      chk(32'(irq), 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({rq[30:0], re}, 32'h1);
      apb(1'b1, `REG_CONTROL, 32'h0);
      apb(1'b0, `REG_CONTROL, 32'h0);
      chk(rq, 32'h0);
      $display("test interrupt done");
   endtask

   initial begin
      #20000;
      failures++;
      conclude();
   end

   initial begin
      failures = 0;
      comparisons = 0;
      reset <= 1'b1;
      {psel, penable, pwrite, instr_done, bp5, bp7, want, use_a, have_trap} <= 9'h000;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      pu <= 5'h00;
      instr_word <= 12'h000;
      pc <= 12'h3c1;
      trap <= 12'h000;
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_enable();
      t_disable();
      t_init(12'h0a5, 1'b1, 1'b0);
      t_init(12'h000, 1'b0, 1'b1);
      t_irq();
      conclude();
   end
endmodule
